// file: src/jtag_debug_identity_port.v
/*
 the file holds the tile test port: a boundary scan controller and a chip controller
 chained after it, identification and user code registers, the debug sync pin and
 the global reset and lock wait.
 it assumes clk at 200 MHz; test clock, test reset, data in, debug pin and global
 reset all come from outside and are synchronised here.
*/
`include "jtag_id_regs.vh"

// Behaviour
// - after reset each tile puts two controllers in the chain, boundary scan then chip access.
// - the boundary scan controller walks the standard sixteen-state test machine over the pins.
// - the chip controller gives the host access to tile state, switch and one-time memory.
// - in output mode the debug pin floats until a breakpoint, then is driven low.
// - in input mode a low on the debug pin puts the tile into debug mode.
// - the identification instruction shifts out a 32-bit version, part and maker word.
// - the user code instruction returns user id bits 31 to 22 from the tile zero security word.
// - global reset asserts three clk cycles after the pin falls, through the synchroniser, and boot waits for clock lock after its release.
// - security bit 0 disables the whole test interface.
// - security bit 13 blocks one-time memory access from the test interface.
// - security bit 14 disables the debug pin entirely.
module jtag_debug_identity_port #(
  parameter [3:0]  VERSION    = 4'h1,     // arbitrary value
  parameter [15:0] PART_NUM   = 16'h1234, // arbitrary value
  parameter [10:0] MFR_ID     = 11'h055,  // arbitrary value
  parameter [11:0] SILICON_REV = 12'h001,
  parameter        LOCK_WAIT  = (`LOCK_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        glob_rst_n,
  input  wire        pll_locked,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  input  wire        trst_n,
  input  wire [31:0] security_word,
  input  wire        debug_out_mode,
  input  wire        breakpoint_hit,
  input  wire        debug_in,
  input  wire [7:0]  bscan_pins_in,
  output reg         tdo_r,
  output reg         tdo_oe_r,
  output reg         debug_out_r,
  output reg         debug_oe_r,
  output reg         debug_mode_r,
  output reg         boot_go_r,
  output reg  [7:0]  bscan_pins_out_r,
  output reg         extest_r,
  output reg         chip_reset_r,
  output reg         otp_blocked_r
);
  localparam [15:0] S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SEL_DR = 16'h0004,
                    S_CAP_DR = 16'h0008, S_SH_DR = 16'h0010, S_EX1_DR = 16'h0020,
                    S_PA_DR = 16'h0040, S_EX2_DR = 16'h0080, S_UP_DR = 16'h0100,
                    S_SEL_IR = 16'h0200, S_CAP_IR = 16'h0400, S_SH_IR = 16'h0800,
                    S_EX1_IR = 16'h1000, S_PA_IR = 16'h2000, S_EX2_IR = 16'h4000,
                    S_UP_IR = 16'h8000;
  localparam [2:0] B_RST = 3'h1, B_LOCK = 3'h2, B_RUN = 3'h4;

  // two-stage synchronisers; stage one is read only by stage two
  reg [13:0] s1_r;
  reg [13:0] s2_r;
  reg        tck_d_r;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      // idle levels: a zero on the pulled-up debug pin would fake a debug request
      s1_r <= `SYNC_RST_VAL;
      s2_r <= `SYNC_RST_VAL;
    end
    else
    begin
      s1_r <= {bscan_pins_in, glob_rst_n, debug_in, trst_n, tdi, tms, tck};
      s2_r <= s1_r;
    end
  end
  wire tck_s = s2_r[0];
  wire tms_s = s2_r[1];
  wire tdi_s = s2_r[2];
  wire trst_s = s2_r[3];
  wire dbg_in_s = s2_r[4];
  wire grst_s = s2_r[5];
  wire [7:0] pin_s = s2_r[13:6];

  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;
  wire jtag_off = security_word[`SEC_JTAG_OFF];
  wire tap_rst = ~trst_s | jtag_off;

  function [15:0] tap_next;
    input [15:0] s;
    input        m;
    begin
      case (s)
        S_RESET:  tap_next = m ? S_RESET : S_IDLE;
        S_IDLE:   tap_next = m ? S_SEL_DR : S_IDLE;
        S_SEL_DR: tap_next = m ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
        S_SH_DR:  tap_next = m ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: tap_next = m ? S_UP_DR : S_PA_DR;
        S_PA_DR:  tap_next = m ? S_EX2_DR : S_PA_DR;
        S_EX2_DR: tap_next = m ? S_UP_DR : S_SH_DR;
        S_UP_DR:  tap_next = m ? S_SEL_DR : S_IDLE;
        S_SEL_IR: tap_next = m ? S_RESET : S_CAP_IR;
        S_CAP_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
        S_SH_IR:  tap_next = m ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: tap_next = m ? S_UP_IR : S_PA_IR;
        S_PA_IR:  tap_next = m ? S_EX2_IR : S_PA_IR;
        S_EX2_IR: tap_next = m ? S_UP_IR : S_SH_IR;
        S_UP_IR:  tap_next = m ? S_SEL_DR : S_IDLE;
        default:  tap_next = S_RESET;
      endcase
    end
  endfunction

  // both controllers share one state machine; their instruction and data paths chain
  reg [15:0]          st_r;
  reg [`IR_LEN-1:0]   bs_ir_r, bs_irs_r, ch_ir_r, ch_irs_r;
  reg [31:0]          bs_dr_r;
  reg [`CHIP_DR_LEN-1:0] ch_dr_r;
  reg                 bs_byp_r, ch_byp_r;

  wire [31:0] ident_word = {VERSION, PART_NUM, MFR_ID, 1'b1};
  wire [31:0] user_word = {security_word[`UC_UID_HI:`UC_UID_LO], 10'h000,
                           SILICON_REV};

  // chip data frame: {write, select[1:0], addr[4:0], data[31:0]}
  wire       ch_wr   = ch_dr_r[39];
  wire [1:0] ch_sel  = ch_dr_r[38:37];
  wire       otp_hit = (ch_sel == `CHIP_SEL_OTP);
  wire       otp_off = security_word[`SEC_OTP_OFF];
  wire       mem_we  = st_r[8] & tck_rise & (ch_ir_r == `IR_CHIP_ACCESS) & ch_wr
                       & ~(otp_hit & otp_off);
  wire [31:0] mem_rd;

  tap_shift_mem #(.AW(3), .DW(32)) u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (mem_we),
    .addr    ({ch_sel[0], ch_dr_r[33:32]}),
    .wdata   (ch_dr_r[31:0]),
    .rdata_r (mem_rd)
  );

  wire bs_out = (bs_ir_r == `IR_BYPASS) ? bs_byp_r : bs_dr_r[0];
  always @(posedge clk)
  begin
    if (!rst_n || tap_rst)
    begin
      st_r     <= S_RESET;
      bs_ir_r  <= `IR_IDENT;
      ch_ir_r  <= `IR_IDENT;
      bs_irs_r <= `IR_CAPTURE;
      ch_irs_r <= `IR_CAPTURE;
      bs_dr_r  <= 32'h00000000;
      ch_dr_r  <= 40'h0000000000;
      bs_byp_r <= 1'b0;
      ch_byp_r <= 1'b0;
      bscan_pins_out_r <= 8'h00;
    end
    else if (tck_rise)
    begin
      st_r <= tap_next(st_r, tms_s);
      case (st_r)
        S_RESET:
        begin
          bs_ir_r <= `IR_IDENT;
          ch_ir_r <= `IR_IDENT;
        end
        S_CAP_IR:
        begin
          bs_irs_r <= `IR_CAPTURE;
          ch_irs_r <= `IR_CAPTURE;
        end
        S_SH_IR:
        begin
          ch_irs_r <= {tdi_s, ch_irs_r[`IR_LEN-1:1]};
          bs_irs_r <= {ch_irs_r[0], bs_irs_r[`IR_LEN-1:1]};
        end
        S_UP_IR:
        begin
          bs_ir_r <= bs_irs_r;
          ch_ir_r <= ch_irs_r;
        end
        S_CAP_DR:
        begin
          bs_byp_r <= 1'b0;
          ch_byp_r <= 1'b0;
          case (bs_ir_r)
            `IR_IDENT:    bs_dr_r <= ident_word;
            `IR_USERCODE: bs_dr_r <= user_word;
            `IR_SAMPLE, `IR_EXTEST: bs_dr_r <= {24'h000000, pin_s};
            default:      bs_dr_r <= 32'h00000000;
          endcase
          case (ch_ir_r)
            `IR_IDENT:       ch_dr_r <= {8'h00, ident_word};
            `IR_USERCODE:    ch_dr_r <= {8'h00, user_word};
            `IR_CHIP_ACCESS: ch_dr_r <= {ch_dr_r[39:32],
                                         (otp_hit & otp_off) ? 32'h00000000 : mem_rd};
            default:         ch_dr_r <= 40'h0000000000;
          endcase
        end
        S_SH_DR:
        begin
          // chip controller sits nearer tdi, boundary scan nearer tdo
          ch_byp_r <= tdi_s;
          ch_dr_r  <= {tdi_s, ch_dr_r[`CHIP_DR_LEN-1:1]};
          bs_byp_r <= (ch_ir_r == `IR_BYPASS) ? ch_byp_r : ch_dr_r[0];
          bs_dr_r  <= {((ch_ir_r == `IR_BYPASS) ? ch_byp_r : ch_dr_r[0]), bs_dr_r[31:1]};
        end
        S_UP_DR:
        begin
          if (bs_ir_r == `IR_EXTEST || bs_ir_r == `IR_SAMPLE)
            bscan_pins_out_r <= bs_dr_r[7:0];
        end
        default:
        begin
          bs_byp_r <= bs_byp_r;
        end
      endcase
    end
  end

  // tdo changes on the falling test clock edge, as the standard asks
  always @(posedge clk)
  begin
    if (!rst_n || tap_rst)
    begin
      tck_d_r  <= 1'b0;
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
      extest_r <= 1'b0;
    end
    else
    begin
      tck_d_r  <= tck_s;
      extest_r <= (bs_ir_r == `IR_EXTEST);
      if (tck_fall)
      begin
        tdo_oe_r <= st_r[4] | st_r[11];
        tdo_r    <= st_r[11] ? bs_irs_r[0] : bs_out;
      end
    end
  end

  // debug pin: open drain low on breakpoint, low input enters debug mode
  wire dbg_off = security_word[`SEC_DBG_OFF];
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      debug_out_r  <= 1'b0;
      debug_oe_r   <= 1'b0;
      debug_mode_r <= 1'b0;
      otp_blocked_r <= 1'b0;
    end
    else
    begin
      otp_blocked_r <= otp_off | jtag_off;
      debug_out_r  <= 1'b0;
      debug_oe_r   <= ~dbg_off & debug_out_mode & (breakpoint_hit | debug_oe_r);
      if (dbg_off)
        debug_mode_r <= 1'b0;
      else if (!debug_out_mode && !dbg_in_s)
        debug_mode_r <= 1'b1;
      else if (debug_out_mode)
        debug_mode_r <= debug_oe_r;
    end
  end

  // global reset: synchronised path still acts in the very next cycle it is seen low
  reg [2:0]  bst_r;
  reg [31:0] lock_cnt_r;
  always @(posedge clk)
  begin
    if (!rst_n || !grst_s)
    begin
      bst_r         <= B_RST;
      lock_cnt_r    <= 32'h00000000;
      boot_go_r     <= 1'b0;
      chip_reset_r  <= 1'b1;
    end
    else
    begin
      case (bst_r)
        B_RST:
        begin
          bst_r        <= B_LOCK;
          chip_reset_r <= 1'b1;
          lock_cnt_r   <= 32'h00000000;
        end
        B_LOCK:
        begin
          if (!pll_locked)
            lock_cnt_r <= 32'h00000000;
          else if (lock_cnt_r >= LOCK_WAIT - 1)
          begin
            bst_r        <= B_RUN;
            chip_reset_r <= 1'b0;
            boot_go_r    <= 1'b1;
          end
          else
            lock_cnt_r <= lock_cnt_r + 32'h00000001;
        end
        B_RUN:
        begin
          boot_go_r <= 1'b0;
          if (!pll_locked)
            bst_r <= B_LOCK;
        end
        default:
          bst_r <= B_RST;
      endcase
    end
  end
endmodule // jtag_debug_identity_port

// file: src/jtag_id_regs.vh
/*
 the file holds the constants of the test port: instruction codes, identification and
 user code field positions, security bit positions and timing figures.
 it assumes inclusion by the test port files only; definitions only.
*/
`ifndef JTAG_ID_REGS_VH
`define JTAG_ID_REGS_VH

`define IR_LEN            4
`define IR_EXTEST         4'h0
`define IR_SAMPLE         4'h1
`define IR_IDENT          4'h2
`define IR_USERCODE       4'h3
`define IR_CHIP_ACCESS    4'h4
`define IR_BYPASS         4'hF
`define IR_CAPTURE        4'h1

`define ID_VER_HI         31
`define ID_VER_LO         28
`define ID_PART_HI        27
`define ID_PART_LO        12
`define ID_MFR_HI         11
`define ID_MFR_LO         1
`define ID_MARK_BIT       0

`define UC_UID_HI         31
`define UC_UID_LO         22
`define UC_UID_W          10

`define SEC_JTAG_OFF      0
`define SEC_OTP_OFF       13
`define SEC_DBG_OFF       14

`define CHIP_DR_LEN       40
`define CHIP_SEL_OTP      2'h2

`define SYNC_RST_VAL      14'h0010
`define CLK_PERIOD_NS     5
`define LOCK_WAIT_NS      1000

`endif

// file: src/tap_shift_mem.v
/*
 the file holds a small register bank for the chip access path: eight 32-bit words
 written and read by the chip controller; read data leave from a register.
 it assumes a single clock and a synchronous active-low reset.
*/
module tap_shift_mem #(
  parameter AW = 3,
  parameter DW = 32
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          wr_en,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata_r
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk)
  begin
    if (wr_en)
      mem[addr] <= wdata;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= {DW{1'b0}};
    else
      rdata_r <= mem[addr];
  end
endmodule // tap_shift_mem

// file: test/jtag_host.sv
/*
 external test host: walks the test state machine with an 80 ns test clock.
 assumes clk at 200 MHz; test clock stands low between frames.
*/
module jtag_host (
  input  wire logic clk,
  input  wire logic tdo_r,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // data out is sampled just before the rise, long after the fall moved it
  task automatic tick(input logic t, input logic d, output logic q);
    tms <= t;
    tdi <= d;
    repeat (8) @(posedge clk);
    q = tdo_r;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir)
      tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule // jtag_host

// file: test/jtag_port_props.sv
/*
 checker for the tile test port: security gating, debug pin, boot wait and resets.
 assumes one clk domain with sync active-low rst_n, bound onto the port top module.
*/
module jtag_port_props #(
  parameter LOCK_WAIT = 4
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        glob_rst_n,
  input wire logic        pll_locked,
  input wire logic        trst_n,
  input wire logic [31:0] security_word,
  input wire logic        debug_out_mode,
  input wire logic        breakpoint_hit,
  input wire logic        tdo_oe_r,
  input wire logic        debug_out_r,
  input wire logic        debug_oe_r,
  input wire logic        debug_mode_r,
  input wire logic        boot_go_r,
  input wire logic        chip_reset_r,
  input wire logic        otp_blocked_r
);
  int lock_cnt;
  // counts locked cycles only; a boot pulse needs at least the full wait behind it
  always @(posedge clk) lock_cnt <= (!rst_n || !pll_locked) ? 0 : lock_cnt + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence quiet_out;
    debug_out_mode && !breakpoint_hit;
  endsequence
  sequence hit_out;
    debug_out_mode && breakpoint_hit && !security_word[14];
  endsequence
  test_off_a: assert property (security_word[0] [*4] |-> !tdo_oe_r)
    else $error("test port shifting while disabled");
  trst_hold_a: assert property (!trst_n [*5] |-> !tdo_oe_r)
    else $error("test logic active under test reset");
  otp_block_a: assert property (security_word[13] [*4] |-> otp_blocked_r)
    else $error("one-time memory not blocked");
  dbg_off_a: assert property (security_word[14] [*4] |-> !debug_oe_r && !debug_mode_r)
    else $error("debug pin active while disabled");
  dbg_float_a: assert property (quiet_out [*3] |-> !$rose(debug_oe_r))
    else $error("debug pin driven without breakpoint");
  dbg_drive_a: assert property (hit_out |-> ##[1:3] debug_oe_r && !debug_out_r)
    else $error("debug pin not driven low after breakpoint");
  chip_rst_a: assert property (!glob_rst_n [*4] |-> chip_reset_r)
    else $error("chip not held in reset");
  boot_wait_a: assert property (boot_go_r |-> lock_cnt >= LOCK_WAIT && !chip_reset_r)
    else $error("boot before lock wait ended");
  boot_pulse_a: assert property (boot_go_r |=> !boot_go_r)
    else $error("boot pulse longer than one cycle");
endmodule // jtag_port_props

bind jtag_debug_identity_port jtag_port_props #(.LOCK_WAIT(LOCK_WAIT)) props_u (
  .clk(clk), .rst_n(rst_n), .glob_rst_n(glob_rst_n), .pll_locked(pll_locked),
  .trst_n(trst_n), .security_word(security_word), .debug_out_mode(debug_out_mode),
  .breakpoint_hit(breakpoint_hit), .tdo_oe_r(tdo_oe_r), .debug_out_r(debug_out_r),
  .debug_oe_r(debug_oe_r), .debug_mode_r(debug_mode_r), .boot_go_r(boot_go_r),
  .chip_reset_r(chip_reset_r), .otp_blocked_r(otp_blocked_r));

// file: test/tb_top.sv
/*
 self-checking bench for the tile test port against an integer model.
 assumes the host model drives the test link and the debug wire has a pull-up.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LW = 4;
  logic        clk, rst_n, glob_rst_n, pll_locked, trst_n, tck, tms, tdi;
  logic        debug_out_mode, breakpoint_hit, ext_low, oe_seen, boot_seen;
  logic [31:0] security_word, base, w;
  logic [7:0]  bscan_pins_in, pins;
  logic [63:0] d;
  logic [9:0]  uid;
  wire         tdo_r, tdo_oe_r, debug_out_r, debug_oe_r, debug_mode_r, boot_go_r;
  wire         extest_r, chip_reset_r, otp_blocked_r;
  wire  [7:0]  bscan_pins_out_r;
  wire         debug_in = !(debug_oe_r | ext_low);
  int          failures, n_tests, cyc, c;
  jtag_debug_identity_port #(.VERSION(4'h1), .PART_NUM(16'h1234), .MFR_ID(11'h055),
    .SILICON_REV(12'h001), .LOCK_WAIT(LW)) dut_u (
    .clk(clk), .rst_n(rst_n), .glob_rst_n(glob_rst_n), .pll_locked(pll_locked),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .security_word(security_word),
    .debug_out_mode(debug_out_mode), .breakpoint_hit(breakpoint_hit), .debug_in(debug_in),
    .bscan_pins_in(bscan_pins_in), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r),
    .debug_out_r(debug_out_r), .debug_oe_r(debug_oe_r), .debug_mode_r(debug_mode_r),
    .boot_go_r(boot_go_r), .bscan_pins_out_r(bscan_pins_out_r), .extest_r(extest_r),
    .chip_reset_r(chip_reset_r), .otp_blocked_r(otp_blocked_r));
  jtag_host host_u (.clk(clk), .tdo_r(tdo_r), .tck(tck), .tms(tms), .tdi(tdi));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (tdo_oe_r === 1'b1) oe_seen <= 1'b1;
    if (boot_go_r === 1'b1) boot_seen <= 1'b1;
    if (cyc == 40000)
    begin
      failures++;
      wrap_up();
    end
  end
  function automatic logic [31:0] exp_id();
    return (32'h1 << 28) | (32'h1234 << 12) | (32'h055 << 1) | 32'h1;
  endfunction
  function automatic logic [31:0] exp_uc(input logic [9:0] u);
    return ({22'h0, u} << 22) | 32'h1;
  endfunction
  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    {rst_n, glob_rst_n, trst_n, debug_out_mode, breakpoint_hit, ext_low} = '0;
    {oe_seen, boot_seen, cyc, failures, n_tests} = '0;
    pll_locked = 1'b1;
    security_word = '0;
    void'($urandom(65));
    base = $urandom & 32'h003F_9FFE;
    bscan_pins_in = $urandom;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (18) @(posedge clk);
    trst_n <= 1'b1;
    glob_rst_n <= 1'b1;
    security_word <= base;
    wclk(20);
    check("dbg_idle", debug_mode_r, 1'b0);
    host_u.tap_reset();
    host_u.scan(0, 32, 64'h0, d);
    check("ident", d[31:0], exp_id());
    check("oe_shift", oe_seen, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      uid = k ? $urandom : 10'h000;
      security_word <= base | ({22'h0, uid} << 22);
      wclk(2);
      host_u.scan(1, 8, 64'hF3, d);
      check("ir_capture", d[7:0], 8'h11);
      host_u.scan(0, 33, 64'h0, d);
      check("usercode", d[31:0], exp_uc(uid));
      host_u.tap_reset();
    end
    host_u.scan(1, 8, 64'hF0, d);
    pins = $urandom;
    check("extest", extest_r, 1'b1);
    host_u.scan(0, 33, {56'h0, pins}, d);
    check("bscan_cap", d[31:0], {24'h0, bscan_pins_in});
    check("bscan_upd", bscan_pins_out_r, pins);
    host_u.scan(1, 8, 64'h4F, d);
    w = $urandom;
    host_u.scan(0, 41, {23'h0, 1'b1, 2'h2, 5'h01, w, 1'b0}, d);
    host_u.scan(0, 41, {23'h0, 1'b0, 2'h2, 5'h01, 32'h0, 1'b0}, d);
    check("chip_rd", d[32:1], w);
    security_word <= base | 32'h0000_2000;
    host_u.scan(0, 41, {23'h0, 1'b1, 2'h2, 5'h01, ~w, 1'b0}, d);
    check("otp_rd_off", d[32:1], 32'h0);
    security_word <= base;
    host_u.scan(0, 41, {23'h0, 1'b0, 2'h2, 5'h01, 32'h0, 1'b0}, d);
    check("otp_wr_off", d[32:1], w);
    host_u.tap_reset();
    for (int m = 0; m < 2; m++)
    begin
      if (m == 0) security_word <= base | 32'h0000_0001;
      else trst_n <= 1'b0;
      wclk(8);
      oe_seen = 1'b0;
      host_u.tap_reset();
      host_u.scan(0, 32, 64'h0, d);
      check("oe_locked", oe_seen, 1'b0);
      check("otp_lock", otp_blocked_r, m == 0);
      security_word <= base;
      trst_n <= 1'b1;
      wclk(1);
    end
    security_word <= base | 32'h0000_2000;
    wclk(4);
    check("otp_block", otp_blocked_r, 1'b1);
    security_word <= base;
    debug_out_mode <= 1'b1;
    wclk(6);
    check("dbg_float", debug_oe_r, 1'b0);
    breakpoint_hit <= 1'b1;
    wclk(1);
    breakpoint_hit <= 1'b0;
    wclk(4);
    check("dbg_drive", {debug_oe_r, debug_out_r}, 2'b10);
    security_word <= base | 32'h0000_4000;
    wclk(4);
    check("dbg_out_off", debug_oe_r, 1'b0);
    security_word <= base;
    debug_out_mode <= 1'b0;
    ext_low <= 1'b1;
    wclk(6);
    check("dbg_mode", debug_mode_r, 1'b1);
    security_word <= base | 32'h0000_4000;
    wclk(4);
    check("dbg_mode_off", debug_mode_r, 1'b0);
    ext_low <= 1'b0;
    security_word <= base;
    glob_rst_n <= 1'b0;
    pll_locked <= 1'b0;
    wclk(5);
    check("chip_reset", chip_reset_r, 1'b1);
    boot_seen = 1'b0;
    glob_rst_n <= 1'b1;
    wclk(LW + 8);
    check("boot_unlocked", boot_seen, 1'b0);
    pll_locked <= 1'b1;
    c = 0;
    while (boot_seen !== 1'b1 && c < 100)
    begin
      wclk(1);
      c++;
    end
    check("boot_go", boot_seen, 1'b1);
    check("lock_wait", c >= LW, 1'b1);
    wrap_up();
  end
endmodule // tb_top
